// File: src/tmd_core.sv
// tmd_core: 4-bit tuner core instruction decode and execute with AXI4-Lite control
// Functional notes
// - ADD sums register and memory nibble, result into register.
// - add-skip variants skip next instruction on carry out.
// - add-with-carry variants add carry flag, store in destination.
// - immediate adds sum immediate and memory, result back in memory.
// - subtract variants use borrow when selected, skip on borrow.
// - register operands address bank zero nibbles 00h to 0fh.
// - AND merges immediate with memory nibble, result in memory.
// - load copies memory nibble into register, memory unchanged.
// - jump loads program counter from address field.
// - call pushes incremented counter, then jumps to address field.
// - both returns pop top stack entry into program counter.
// - status set raises masked bits of status register one.
// - status clear lowers masked bits of status register one.
// - status tests skip when masked status-two bits all match.
// - bank select latches bank for later memory accesses.
// - converting display write makes 7-segment pattern; direct write does not.
// - port input stores selected port value into memory.
// - port output writes memory nibble into port output latch.
// - port bit set/clear changes only masked latch bits.
// - port tests skip when masked port bits all ones/zeros.
// - port F direction latch loads mask; one means output.
// - clock halt stops core only while hold input is low.
// - port E turns input on input/test, output on output/bit ops.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "tmd_map.svh"

module tmd_core (
    input  wire logic              core_clk_i,
    input  wire logic              srst_i,
    output logic                   pc_o,
    output tmd_pkg::tmd_pc_t       pc_addr_o,
    input  wire tmd_pkg::tmd_instr_t instr_i,
    input  wire logic              hold_i,
    input  wire tmd_pkg::tmd_nib_t st2_i,
    output tmd_pkg::tmd_nib_t      st1_o,
    input  wire tmd_pkg::tmd_nib_t pa_i,
    input  wire tmd_pkg::tmd_nib_t pg_i,
    output tmd_pkg::tmd_nib_t      pb_o,
    output tmd_pkg::tmd_nib_t      pc_port_o,
    output tmd_pkg::tmd_nib_t      pd_o,
    input  wire tmd_pkg::tmd_nib_t pe_i,
    output tmd_pkg::tmd_nib_t      pe_o,
    output tmd_pkg::tmd_nib_t      pe_oe_n_o,
    input  wire tmd_pkg::tmd_nib_t pf_i,
    output tmd_pkg::tmd_nib_t      pf_o,
    output tmd_pkg::tmd_nib_t      pf_oe_n_o,
    output tmd_pkg::tmd_nib_t      ph_o,
    output tmd_pkg::tmd_nib_t      ph_oe_n_o,
    output logic                   lcd_wr_o,
    output tmd_pkg::tmd_nib_t      lcd_digit_o,
    output logic [6:0]             lcd_seg_o,
    output logic                   halted_o,
    input  wire logic [7:0]        s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [7:0]        s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i
);
    import tmd_pkg::*;

    tmd_state_t  state_q;
    tmd_pc_t     pc_q;
    tmd_pc_t     pc_d;
    tmd_pc_t     pc_inc;
    tmd_pc_t     stk_q [4];
    logic [1:0]  sp_q;
    tmd_nib_t    mem_q [256];
    tmd_nib_t    out_q [16];
    tmd_nib_t    st1_q;
    tmd_nib_t    st1_d;
    logic [1:0]  bank_q;
    logic [1:0]  bank_d;
    logic        cf_q;
    logic        edir_q;
    logic        edir_d;
    tmd_nib_t    fdir_q;
    tmd_nib_t    fdir_d;
    logic        run_q;
    logic [5:0]  opc;
    logic [3:0]  jop;
    logic [7:0]  maddr;
    logic [7:0]  raddr;
    tmd_nib_t    imm;
    tmd_nib_t    pn_io;
    tmd_nib_t    pn_bit;
    tmd_nib_t    m_rd;
    tmd_nib_t    r_rd;
    logic        arith;
    tmd_nib_t    a_op;
    tmd_nib_t    b_op;
    logic        cin;
    logic [4:0]  alu_res;
    logic        exec;
    logic        mem_we;
    logic [7:0]  mem_wa;
    tmd_nib_t    mem_wd;
    logic        cf_we;
    logic        cond;
    logic        push;
    logic        pop;
    logic        out_we;
    tmd_nib_t    out_pn;
    tmd_nib_t    out_d;
    logic        lcd_we;
    logic [6:0]  lcd_d;
    logic        halt_req;
    logic [7:0]  aw_addr_q;
    logic        aw_v_q;
    logic        w_v_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    // 7-segment pattern for a hex digit, segments g..a
    function automatic logic [6:0] seg7(input tmd_nib_t v);
        case (v)
            4'h0: seg7 = 7'h3f;
            4'h1: seg7 = 7'h06;
            4'h2: seg7 = 7'h5b;
            4'h3: seg7 = 7'h4f;
            4'h4: seg7 = 7'h66;
            4'h5: seg7 = 7'h6d;
            4'h6: seg7 = 7'h7d;
            4'h7: seg7 = 7'h07;
            4'h8: seg7 = 7'h7f;
            4'h9: seg7 = 7'h6f;
            4'ha: seg7 = 7'h77;
            4'hb: seg7 = 7'h7c;
            4'hc: seg7 = 7'h39;
            4'hd: seg7 = 7'h5e;
            4'he: seg7 = 7'h79;
            default: seg7 = 7'h71;
        endcase
    endfunction

    // input ports read pins; output-only ports read back their latch
    function automatic tmd_nib_t port_rd(input tmd_nib_t pn);
        case (pn)
            `TMD_P_A: port_rd = pa_i;
            `TMD_P_E: port_rd = pe_i;
            `TMD_P_F: port_rd = pf_i;
            `TMD_P_G: port_rd = pg_i;
            default:  port_rd = out_q[pn];
        endcase
    endfunction

    assign opc    = instr_i[`TMD_F_OPC];
    assign jop    = instr_i[`TMD_F_JOP];
    assign imm    = instr_i[`TMD_F_LO];
    assign pn_io  = instr_i[`TMD_F_LO];
    assign pn_bit = instr_i[`TMD_F_PNB];
    assign maddr  = {bank_q, instr_i[`TMD_F_DH], instr_i[`TMD_F_DL]};
    assign raddr  = {`TMD_REG_HI, instr_i[`TMD_F_LO]};
    assign m_rd   = mem_q[maddr];
    assign r_rd   = mem_q[raddr];
    assign arith  = (opc[5:4] == `TMD_ARITH);
    // held reset must not let word zero write memory
    assign exec   = run_q && (state_q == ST_RUN) && !srst_i;
    assign pc_inc = pc_q + 12'h001;

    assign a_op = opc[`TMD_B_MEM] ? m_rd : r_rd;
    assign b_op = opc[`TMD_B_MEM] ? imm : m_rd;
    assign cin  = opc[`TMD_B_CRY] & cf_q;
    // borrow shows as bit 4 of the difference
    assign alu_res = opc[`TMD_B_SUB]
                   ? ({1'b0, a_op} - {1'b0, b_op} - {4'h0, cin})
                   : ({1'b0, a_op} + {1'b0, b_op} + {4'h0, cin});

    always_comb
    begin
        pc_d     = pc_q;
        mem_we   = 1'b0;
        mem_wa   = maddr;
        mem_wd   = alu_res[3:0];
        cf_we    = 1'b0;
        cond     = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        st1_d    = st1_q;
        bank_d   = bank_q;
        out_we   = 1'b0;
        out_pn   = pn_bit;
        out_d    = m_rd;
        edir_d   = edir_q;
        fdir_d   = fdir_q;
        lcd_we   = 1'b0;
        lcd_d    = {3'h0, m_rd};
        halt_req = 1'b0;
        // skipped word only moves the counter
        if (run_q && state_q == ST_SKIP)
            pc_d = pc_inc;
        if (exec)
        begin
            pc_d = pc_inc;
            if (jop == `TMD_J_JMP)
                pc_d = instr_i[`TMD_F_ADDR];
            else if (jop == `TMD_J_CAL)
            begin
                push = 1'b1;
                pc_d = instr_i[`TMD_F_ADDR];
            end
            else if (arith)
            begin
                mem_we = 1'b1;
                mem_wa = opc[`TMD_B_MEM] ? maddr : raddr;
                cf_we  = 1'b1;
                cond   = opc[`TMD_B_SKP] & alu_res[4];
            end
            else
            begin
                case (opc)
                    `TMD_OP_AND:
                    begin
                        mem_we = 1'b1;
                        mem_wd = m_rd & imm;
                    end
                    `TMD_OP_OR:
                    begin
                        mem_we = 1'b1;
                        mem_wd = m_rd | imm;
                    end
                    `TMD_OP_XOR:
                    begin
                        mem_we = 1'b1;
                        mem_wa = raddr;
                        mem_wd = r_rd ^ m_rd;
                    end
                    `TMD_OP_LDR:
                    begin
                        mem_we = 1'b1;
                        mem_wa = raddr;
                        mem_wd = m_rd;
                    end
                    `TMD_OP_STR:
                    begin
                        mem_we = 1'b1;
                        mem_wd = r_rd;
                    end
                    `TMD_OP_SSET: st1_d = st1_q | imm;
                    `TMD_OP_SCLR: st1_d = st1_q & ~imm;
                    `TMD_OP_ST1S: cond = ((st2_i & imm) == imm);
                    `TMD_OP_ST0S: cond = ((st2_i & imm) == 4'h0);
                    `TMD_OP_BANK: bank_d = instr_i[`TMD_F_BANK];
                    `TMD_OP_DDIR: lcd_we = 1'b1;
                    `TMD_OP_DSEG:
                    begin
                        lcd_we = 1'b1;
                        lcd_d  = seg7(m_rd);
                    end
                    `TMD_OP_PIN:
                    begin
                        mem_we = 1'b1;
                        mem_wd = port_rd(pn_io);
                        if (pn_io == `TMD_P_E)
                            edir_d = 1'b0;
                    end
                    `TMD_OP_POUT:
                    begin
                        out_we = 1'b1;
                        out_pn = pn_io;
                        if (pn_io == `TMD_P_E)
                            edir_d = 1'b1;
                    end
                    `TMD_OP_PSET, `TMD_OP_PCLR:
                    begin
                        out_we = 1'b1;
                        out_d  = (opc == `TMD_OP_PSET) ? (out_q[pn_bit] | imm)
                                                       : (out_q[pn_bit] & ~imm);
                        if (pn_bit == `TMD_P_E)
                            edir_d = 1'b1;
                    end
                    `TMD_OP_TPT, `TMD_OP_TPF:
                    begin
                        cond = (opc == `TMD_OP_TPT)
                             ? ((port_rd(pn_bit) & imm) == imm)
                             : ((port_rd(pn_bit) & imm) == 4'h0);
                        if (pn_bit == `TMD_P_E)
                            edir_d = 1'b0;
                    end
                    `TMD_OP_FPD: fdir_d = imm;
                    `TMD_OP_HLT: halt_req = ~hold_i;
                    `TMD_OP_RET, `TMD_OP_RTH:
                    begin
                        pop  = 1'b1;
                        pc_d = stk_q[sp_q - 2'd1];
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            state_q <= ST_RUN;
        else
        begin
            case (state_q)
                ST_RUN:
                    if (exec && halt_req)
                        state_q <= ST_HALT;
                    else if (exec && cond)
                        state_q <= ST_SKIP;
                ST_SKIP:
                    if (run_q)
                        state_q <= ST_RUN;
                ST_HALT:
                    // leaving halt needs hold high again
                    if (hold_i)
                        state_q <= ST_RUN;
                default: state_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            pc_q <= `TMD_PC_RST;
        else
            pc_q <= pc_d;
    end

    // return stack wraps silently past four levels
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            sp_q <= 2'd0;
        else if (push)
        begin
            stk_q[sp_q] <= pc_inc;
            sp_q        <= sp_q + 2'd1;
        end
        else if (pop)
            sp_q <= sp_q - 2'd1;
    end

    // data memory has no reset, as in the original part
    always_ff @(posedge core_clk_i)
    begin
        if (mem_we)
            mem_q[mem_wa] <= mem_wd;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            cf_q <= 1'b0;
        else if (cf_we)
            cf_q <= alu_res[4];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            st1_q  <= 4'h0;
            bank_q <= 2'd0;
            edir_q <= 1'b0;
            fdir_q <= 4'h0;
        end
        else
        begin
            st1_q  <= st1_d;
            bank_q <= bank_d;
            edir_q <= edir_d;
            fdir_q <= fdir_d;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < 16; i++)
                out_q[i] <= 4'h0;
        end
        else if (out_we)
            out_q[out_pn] <= out_d;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            lcd_wr_o    <= 1'b0;
            lcd_digit_o <= 4'h0;
            lcd_seg_o   <= 7'h00;
        end
        else
        begin
            lcd_wr_o <= lcd_we;
            if (lcd_we)
            begin
                lcd_digit_o <= instr_i[`TMD_F_LO];
                lcd_seg_o   <= lcd_d;
            end
        end
    end

    assign pc_o      = exec;
    assign pc_addr_o = pc_q;
    assign st1_o     = st1_q;
    assign halted_o  = (state_q == ST_HALT);
    assign pb_o      = out_q[`TMD_P_B];
    assign pc_port_o = out_q[`TMD_P_C];
    assign pd_o      = out_q[`TMD_P_D];
    assign pe_o      = out_q[`TMD_P_E];
    assign pe_oe_n_o = {4{~edir_q}};
    assign pf_o      = out_q[`TMD_P_F];
    assign pf_oe_n_o = ~fdir_q;
    // open drain: latch one pulls the pin low
    assign ph_o      = 4'h0;
    assign ph_oe_n_o = ~out_q[`TMD_P_H];

    // axi4-lite slave, one outstanding write and read
    assign s_axi_awready_o = ~aw_v_q & ~s_axi_bvalid_o;
    assign s_axi_wready_o  = ~w_v_q & ~s_axi_bvalid_o;
    assign s_axi_arready_o = ~s_axi_rvalid_o;

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            aw_v_q         <= 1'b0;
            w_v_q          <= 1'b0;
            aw_addr_q      <= 8'h00;
            w_data_q       <= 32'h0;
            w_strb_q       <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `TMD_R_OK;
            run_q          <= `TMD_RUN_RST;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_v_q    <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_v_q    <= 1'b1;
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end
            if (aw_v_q && w_v_q)
            begin
                aw_v_q         <= 1'b0;
                w_v_q          <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= (aw_addr_q == `TMD_A_CTRL) ? `TMD_R_OK : `TMD_R_DEC;
                if (aw_addr_q == `TMD_A_CTRL && w_strb_q[0])
                    run_q <= w_data_q[0];
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0;
            s_axi_rresp_o  <= `TMD_R_OK;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= `TMD_R_OK;
            case (s_axi_araddr_i)
                `TMD_A_CTRL: s_axi_rdata_o <= {31'h0, run_q};
                `TMD_A_STAT: s_axi_rdata_o <= {13'h0, halted_o, state_q == ST_SKIP,
                                               cf_q, bank_q, sp_q, pc_q};
                `TMD_A_DIAG: s_axi_rdata_o <= {23'h0, edir_q, fdir_q, st1_q};
                default:
                begin
                    s_axi_rdata_o <= 32'h0;
                    s_axi_rresp_o <= `TMD_R_DEC;
                end
            endcase
        end
        else if (s_axi_rvalid_o && s_axi_rready_i)
            s_axi_rvalid_o <= 1'b0;
    end

endmodule // tmd_core

// File: include/tmd_map.svh
// tmd_map.svh: instruction fields, opcodes, port numbers and register offsets
`ifndef TMD_MAP_SVH
`define TMD_MAP_SVH
`define TMD_F_OPC   15:10
`define TMD_F_JOP   15:12
`define TMD_F_ADDR  11:0
`define TMD_F_DH    9:8
`define TMD_F_DL    7:4
`define TMD_F_PNB   7:4
`define TMD_F_LO    3:0
`define TMD_F_BANK  1:0
`define TMD_J_JMP   4'hc
`define TMD_J_CAL   4'hd
`define TMD_ARITH   2'b01
`define TMD_B_SUB   3
`define TMD_B_MEM   2
`define TMD_B_CRY   1
`define TMD_B_SKP   0
`define TMD_OP_NOP  6'h00
`define TMD_OP_TPT  6'h08
`define TMD_OP_TPF  6'h09
`define TMD_OP_FPD  6'h0a
`define TMD_OP_HLT  6'h0b
`define TMD_OP_RET  6'h0c
`define TMD_OP_RTH  6'h0d
`define TMD_OP_AND  6'h20
`define TMD_OP_OR   6'h21
`define TMD_OP_XOR  6'h22
`define TMD_OP_LDR  6'h23
`define TMD_OP_STR  6'h24
`define TMD_OP_SSET 6'h25
`define TMD_OP_SCLR 6'h26
`define TMD_OP_ST1S 6'h27
`define TMD_OP_ST0S 6'h28
`define TMD_OP_BANK 6'h29
`define TMD_OP_DDIR 6'h2a
`define TMD_OP_DSEG 6'h2b
`define TMD_OP_PIN  6'h2c
`define TMD_OP_POUT 6'h2d
`define TMD_OP_PSET 6'h2e
`define TMD_OP_PCLR 6'h2f
`define TMD_P_A     4'h0
`define TMD_P_B     4'h1
`define TMD_P_C     4'h2
`define TMD_P_D     4'h3
`define TMD_P_E     4'h4
`define TMD_P_F     4'h5
`define TMD_P_G     4'h6
`define TMD_P_H     4'h7
`define TMD_REG_HI  4'h0
`define TMD_PC_RST  12'h000
`define TMD_RUN_RST 1'b1
`define TMD_A_CTRL  8'h00
`define TMD_A_STAT  8'h04
`define TMD_A_DIAG  8'h08
`define TMD_R_OK    2'b00
`define TMD_R_DEC   2'b11
`endif

// File: include/tmd_pkg.sv
// tmd_pkg: types shared by the tuner core decoder
package tmd_pkg;
    typedef logic [3:0]  tmd_nib_t;
    typedef logic [11:0] tmd_pc_t;
    typedef logic [15:0] tmd_instr_t;
    typedef enum logic [1:0] {ST_RUN, ST_SKIP, ST_HALT} tmd_state_t;
endpackage

// File: verif/tmd_core_asserts.sv
// tmd_core_asserts: port-level checks on the tuner core decode
`timescale 1ns/10ps
`include "tmd_map.svh"
module tmd_core_asserts (
    input wire logic                core_clk_i,
    input wire logic                srst_i,
    input wire logic                pc_o,
    input wire tmd_pkg::tmd_pc_t    pc_addr_o,
    input wire tmd_pkg::tmd_instr_t instr_i,
    input wire logic                hold_i,
    input wire tmd_pkg::tmd_nib_t   st2_i,
    input wire tmd_pkg::tmd_nib_t   st1_o,
    input wire tmd_pkg::tmd_nib_t   pe_oe_n_o,
    input wire tmd_pkg::tmd_nib_t   pf_oe_n_o,
    input wire logic                halted_o
);
    import tmd_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);
    wire logic [5:0] opc = instr_i[`TMD_F_OPC];
    wire tmd_nib_t   msk = instr_i[`TMD_F_LO];
    wire tmd_pc_t    adr = instr_i[`TMD_F_ADDR];
    // skipped word: one dead cycle, counter moves two
    sequence skip_seq;
        ##1 !pc_o ##1 pc_addr_o == $past(pc_addr_o, 2) + 12'h002;
    endsequence
    jump_load_a: assert property (pc_o && instr_i[`TMD_F_JOP] == `TMD_J_JMP
        |=> pc_addr_o == $past(adr)) else $error("jump target not loaded");
    call_load_a: assert property (pc_o && instr_i[`TMD_F_JOP] == `TMD_J_CAL
        |=> pc_addr_o == $past(adr)) else $error("call target not loaded");
    set_bits_a: assert property (pc_o && opc == `TMD_OP_SSET
        |=> st1_o == ($past(st1_o) | $past(msk))) else $error("status set wrong");
    clear_bits_a: assert property (pc_o && opc == `TMD_OP_SCLR
        |=> st1_o == ($past(st1_o) & ~$past(msk))) else $error("status clear wrong");
    test_ones_a: assert property (pc_o && opc == `TMD_OP_ST1S && msk != 4'h0
        && (st2_i & msk) == msk |-> skip_seq) else $error("ones test did not skip");
    test_zeros_a: assert property (pc_o && opc == `TMD_OP_ST0S && msk != 4'h0
        && (st2_i & msk) == 4'h0 |-> skip_seq) else $error("zeros test did not skip");
    fdir_load_a: assert property (pc_o && opc == `TMD_OP_FPD
        |=> pf_oe_n_o == ~$past(msk)) else $error("port f direction wrong");
    halt_enter_a: assert property (pc_o && opc == `TMD_OP_HLT && !hold_i
        |=> halted_o) else $error("halt not entered");
    halt_ignore_a: assert property (pc_o && opc == `TMD_OP_HLT && hold_i
        |=> !halted_o) else $error("halt taken with hold high");
    port_e_in_a: assert property (pc_o && opc == `TMD_OP_PIN && msk == `TMD_P_E
        |=> pe_oe_n_o == 4'hf) else $error("port e not input");
    port_e_out_a: assert property (pc_o && opc == `TMD_OP_POUT && msk == `TMD_P_E
        |=> pe_oe_n_o == 4'h0) else $error("port e not output");
endmodule // tmd_core_asserts

bind tmd_core tmd_core_asserts tmd_core_asserts_inst (
    .core_clk_i, .srst_i, .pc_o, .pc_addr_o, .instr_i, .hold_i, .st2_i, .st1_o,
    .pe_oe_n_o, .pf_oe_n_o, .halted_o
);

// File: verif/tmd_core_test.sv
// tmd_core_test: self-checking bench for the tuner core
`timescale 1ns/10ps
`include "tmd_map.svh"
module tmd_core_test;
    import tmd_pkg::*;
    logic        core_clk_i, srst_i, pc_o, hold_i, lcd_wr_o, halted_o;
    logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
    logic        s_axi_rvalid_o, s_axi_rready_i;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rr;
    logic [6:0]  lcd_seg_o;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [3:0]  s_axi_wstrb_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd, p;
    tmd_pc_t     pc_addr_o;
    tmd_instr_t  instr_i;
    tmd_instr_t  rom [0:31];
    tmd_nib_t    st2_i, st1_o, pa_i, pg_i, pb_o, pc_port_o, pd_o, pe_i, pe_o, pe_oe_n_o;
    tmd_nib_t    pf_i, pf_o, pf_oe_n_o, ph_o, ph_oe_n_o, lcd_digit_o;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    // async program store, as the core expects
    assign instr_i = rom[pc_addr_o[4:0]];
    tmd_core tmd_core_inst (.*);

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    // program is loaded under reset, so the old one never sees it
    task automatic load(input tmd_instr_t w[$], input logic h);
        foreach (rom[i])
            rom[i] = (i < w.size()) ? w[i] : 16'h0000;
        hold_i <= h;
        srst_i <= 1'b1;
        repeat (16) @(posedge core_clk_i);
        srst_i <= 1'b0;
    endtask

    task automatic run_to(input tmd_pc_t a);
        for (int n = 0; n < 300 && pc_addr_o !== a; n++)
            @(posedge core_clk_i);
        repeat (2) @(posedge core_clk_i);
        chk("pc", a, pc_addr_o);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            if (s_axi_awready_o)
                s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o)
                s_axi_wvalid_i <= 1'b0;
        end
        while (!s_axi_bvalid_o);
        rr = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            if (s_axi_arready_o)
                s_axi_arvalid_i <= 1'b0;
        end
        while (!s_axi_rvalid_o);
        rd = s_axi_rdata_o;
        rr = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic t_arith;
        load('{16'h8000, 16'h5009, 16'h8010, 16'h5018, 16'h4410, 16'h5001, 16'h4810, 16'h5c17,
               16'h5c11, 16'h5001, 16'h6410, 16'h7413, 16'h5001, 16'h7811, 16'hb401, 16'hb412,
               16'hc010}, 1'b1);
        run_to(12'h010);
        chk("pb", 4'ha, pb_o);
        chk("pc_port", 4'hb, pc_port_o);
    endtask

    task automatic t_flow;
        load('{16'hd005, 16'hb431, 16'hb422, 16'hd00c, 16'hc004, 16'h8020, 16'h502f, 16'h8026,
               16'h8c23, 16'h3000, 16'h0000, 16'h0000, 16'hb423, 16'h3400}, 1'b1);
        run_to(12'h004);
        chk("pb", 4'h6, pb_o);
        chk("pc_port", 4'h6, pc_port_o);
        chk("pd", 4'h6, pd_o);
    endtask

    task automatic t_status;
        st2_i <= 4'h5;
        load('{16'h940a, 16'h9802, 16'h9c05, 16'h9401, 16'ha00a, 16'h9402, 16'h9c03, 16'h9404,
               16'h2c00, 16'hc009}, 1'b1);
        run_to(12'h009);
        chk("st1", 4'hc, st1_o);
    endtask

    task automatic t_ports;
        pa_i <= 4'h5;
        pg_i <= 4'hc;
        pe_i <= 4'h3;
        load('{16'hb040, 16'hb441, 16'hb82c, 16'hbc24, 16'h2806, 16'h2005, 16'hb831, 16'h2463,
               16'hb832, 16'h2002, 16'hb834, 16'hb054, 16'hb454, 16'hb859, 16'hb876,
               16'hc00f}, 1'b1);
        run_to(12'h00f);
        chk("pf", 4'h9, pf_o);
        chk("ph_oe_n", 4'h9, ph_oe_n_o);
        chk("ph", 4'h0, ph_o);
        chk("pb", 4'h5, pb_o);
        chk("pc_port", 4'h8, pc_port_o);
        chk("pd", 4'h4, pd_o);
        chk("pf_oe_n", 4'h9, pf_oe_n_o);
        chk("pe", 4'h3, pe_o);
        chk("pe_oe_n", 4'h0, pe_oe_n_o);
    endtask

    task automatic t_halt;
        load('{16'h8000, 16'h5001, 16'ha401, 16'h8000, 16'h5008, 16'hac03, 16'ha400, 16'h2c00,
               16'hac02, 16'ha802, 16'hc00a}, 1'b0);
        repeat (30) @(posedge core_clk_i);
        chk("halted", 1'b1, halted_o);
        chk("seg", 7'h7f, lcd_seg_o);
        hold_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk("lcd_wr", 1'b1, lcd_wr_o);
        chk("seg", 7'h06, lcd_seg_o);
        run_to(12'h00a);
        chk("seg", 7'h01, lcd_seg_o);
        chk("digit", 4'h2, lcd_digit_o);
        chk("halted", 1'b0, halted_o);
    endtask

    task automatic t_regs;
        load('{16'h0000}, 1'b1);
        axi_rd(`TMD_A_CTRL);
        chk("ctrl", 1'b1, rd[0]);
        axi_wr(`TMD_A_CTRL, 32'h0);
        chk("bresp", `TMD_R_OK, rr);
        axi_rd(`TMD_A_STAT);
        p = rd;
        axi_wr(8'h0c, 32'h1);
        chk("bresp", `TMD_R_DEC, rr);
        repeat (5) @(posedge core_clk_i);
        axi_rd(`TMD_A_STAT);
        chk("pc_held", p[11:0], rd[11:0]);
        axi_rd(8'h0c);
        chk("resp", `TMD_R_DEC, rr);
        chk("rdata", 32'h0, rd);
        axi_wr(`TMD_A_CTRL, 32'h1);
        repeat (3) @(posedge core_clk_i);
        axi_rd(`TMD_A_STAT);
        chk("pc_moves", 1'b1, rd[11:0] !== p[11:0]);
    endtask

    initial
    begin
        {srst_i, hold_i, st2_i, pa_i, pg_i, pe_i, pf_i} = {2'b11, 20'h0};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        s_axi_wstrb_i = 4'hf;
        @(posedge core_clk_i);
        t_arith();
        t_flow();
        t_status();
        t_ports();
        t_halt();
        t_regs();
        print_verdict();
    end
endmodule // tmd_core_test
